// ==== dv/board_logic_model.sv ====
// board-side pin drivers; i2c lines pulled up, the other lines pulled down
`timescale 1ns/100ps
module board_logic_model (
    // device pads
    input  wire logic [6:0] dev_out,
    input  wire logic [6:0] dev_oe,
    // board drive
    input  wire logic [6:0] ext_en,
    input  wire logic [6:0] ext_val,
    // resolved level
    output logic      [6:0] pin_lvl
);
    localparam logic [6:0] PULL_UP = 7'h06;

    always_comb
    begin
        // board only drives lines it was told to; undriven lines sit at their pull level
        for (int i = 0; i < 7; i++)
            pin_lvl[i] = dev_oe[i] ? dev_out[i] : (ext_en[i] ? ext_val[i] : PULL_UP[i]);
    end
endmodule

// ==== dv/multifunction_pins_properties.sv ====
// port-level assertions for the multifunction pin block
`timescale 1ns/100ps
module multifunction_pins_properties #(
    parameter int STRAP_CYCLES = 4
) (
    // clock and reset
    input wire logic         core_clk,
    input wire logic         rst_b,
    // eeprom master
    input wire logic         eeprom_master_en,
    input wire logic         eeprom_scl_low,
    // startup configuration
    input wire logic         startup_done,
    input wire logic         serial_is_i2c,
    input wire logic         eeprom_autoload,
    input wire logic [6:0]   i2c_address,
    // pads
    input wire logic [6:0]   multifunction_pin_in,
    input wire logic [6:0]   multifunction_pin_out,
    input wire logic [6:0]   multifunction_pin_oe,
    input wire logic [6:0]   multifunction_pin_weak
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> multifunction_pin_oe == 7'h00)
        else $error("pad driven in reset");
    a_strap_quiet: assert property (!startup_done |-> multifunction_pin_oe == 7'h00)
        else $error("pad driven in strap window");
    a_startup_len: assert property ($rose(rst_b) |-> ##[1:64] $rose(startup_done))
        else $error("strap window did not end");
    a_strap_latch: assert property ($rose(startup_done) |->
        {i2c_address[1:0], serial_is_i2c, eeprom_autoload} == multifunction_pin_in[6:3])
        else $error("strap levels not latched");
    a_addr_base: assert property (i2c_address[6:2] == 5'h12)
        else $error("address outside 0x48..0x4b");
    a_addr_stable: assert property (startup_done && $past(startup_done) |-> $stable(i2c_address))
        else $error("address changed after startup");
    a_weak_drives: assert property ((multifunction_pin_weak & ~multifunction_pin_oe) == 7'h00)
        else $error("weak set on released pad");
    a_eeprom_od: assert property (startup_done && eeprom_master_en ##1 eeprom_master_en |->
        multifunction_pin_out[2:1] == 2'h0 && multifunction_pin_oe[1] == $past(eeprom_scl_low))
        else $error("eeprom master pads not open drain");

    c_startup: cover property ($rose(startup_done));
    c_eeprom: cover property (startup_done && eeprom_master_en);
    c_weak: cover property (multifunction_pin_weak != 7'h00);
endmodule

// ==== dv/multifunction_pins_tb_top.sv ====
// self-checking bench for the multifunction pin block
`timescale 1ns/100ps
module multifunction_pins_tb_top;
    logic         core_clk, rst_b, reg_wr_en, reg_rd_en, io_update;
    logic [15:0]  reg_addr;
    logic [7:0]   reg_wdata, reg_rdata;
    logic [127:0] status_sources, control_dest;
    logic         eeprom_master_en, eeprom_scl_low, eeprom_sda_low;
    logic         startup_done, serial_is_i2c, eeprom_autoload, sda_lvl;
    logic [6:0]   i2c_address, pin_lvl, pin_out, pin_oe, pin_weak, ext_en, ext_val;
    int           error_cnt, compares;

    multifunction_pins #(.STRAP_CYCLES(4)) u_multifunction_pins (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .io_update(io_update),
        .status_sources(status_sources), .control_dest(control_dest), .eeprom_master_en(eeprom_master_en),
        .eeprom_scl_low(eeprom_scl_low), .eeprom_sda_low(eeprom_sda_low), .eeprom_sda_level(sda_lvl),
        .startup_done(startup_done), .serial_is_i2c(serial_is_i2c), .eeprom_autoload(eeprom_autoload),
        .i2c_address(i2c_address), .multifunction_pin_in(pin_lvl), .multifunction_pin_out(pin_out),
        .multifunction_pin_oe(pin_oe), .multifunction_pin_weak(pin_weak));
    board_logic_model u_board_logic_model (.dev_out(pin_out), .dev_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pin_lvl));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask
    task automatic upd;
        @(negedge core_clk);
        io_update = 1'b1;
        @(negedge core_clk);
        io_update = 1'b0;
    endtask
    task automatic test_done;
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic s_startup;
        logic [7:0] d;
        for (int n = 0; startup_done !== 1'b1; n++)
        begin
            chk({1'b0, pin_oe}, 8'h00);
            if (n == 100)
            begin
                error_cnt++;
                test_done();
            end
            cyc(1);
        end
        chk({7'h00, serial_is_i2c}, 8'h01);
        chk({7'h00, eeprom_autoload}, 8'h01);
        chk({1'b0, i2c_address}, 8'h49);
        rd(16'h010A, d);
        chk(d, 8'h07);
        ext_val = 7'h48;
        cyc(10);
        chk({1'b0, i2c_address}, 8'h49);
        ext_en = 7'h08;
        ext_val = 7'h00;
    endtask

    task automatic s_status;
        logic [7:0] d;
        status_sources[1] = 1'b1;
        wr(16'h0102, 8'h81);
        cyc(3);
        chk({7'h00, pin_oe[0]}, 8'h00);
        rd(16'h0102, d);
        chk(d, 8'h81);
        upd();
        cyc(2);
        chk({6'h00, pin_oe[0], pin_out[0]}, 8'h03);
        for (int s = 0; s < 4; s++)
            for (int v = 0; v < 2; v++)
            begin
                wr(16'h0100, 8'(s));
                status_sources[1] = v[0];
                upd();
                cyc(3);
                chk({6'h00, pin_oe[0], pin_out[0]}, {6'h00, s[1] ? v[0] : 1'b1, s[1] ? ~s[0] : v[0] ^ s[0]});
            end
        wr(16'h0100, 8'h00);
        wr(16'h0109, 8'h01);
        upd();
        cyc(2);
        chk({7'h00, pin_weak[0]}, 8'h01);
        rd(16'h0110, d);
        chk(d, 8'h00);
        eeprom_master_en = 1'b1;
        eeprom_scl_low = 1'b1;
        cyc(3);
        chk({4'h0, pin_oe[2:1], pin_out[2:1]}, 8'h04);
        chk({7'h00, sda_lvl}, 8'h01);
        eeprom_sda_low = 1'b1;
        cyc(6);
        chk({7'h00, sda_lvl}, 8'h00);
        eeprom_master_en = 1'b0;
        eeprom_scl_low = 1'b0;
        eeprom_sda_low = 1'b0;
        wr(16'h0102, 8'h00);
        cyc(2);
        chk({7'h00, pin_oe[0]}, 8'h01);
        upd();
        cyc(2);
        chk({7'h00, pin_oe[0]}, 8'h00);
    endtask

    task automatic s_control;
        wr(16'h0105, 8'h05);
        upd();
        ext_val = 7'h08;
        cyc(8);
        chk({7'h00, control_dest[5]}, 8'h01);
        ext_val = 7'h00;
        cyc(8);
        chk({7'h00, control_dest[5]}, 8'h00);
        wr(16'h0105, 8'h06);
        ext_val = 7'h08;
        cyc(8);
        chk({6'h00, control_dest[6:5]}, 8'h00);
        upd();
        cyc(8);
        chk({6'h00, control_dest[6:5]}, 8'h02);
        for (int c = 0; c < 4; c++)
        begin
            wr(16'h0100, 8'(c << 6));
            upd();
            cyc(8);
            chk({7'h00, control_dest[6]}, {7'h00, ~c[0]});
        end
    endtask

    initial
    begin
        error_cnt = 0;
        compares = 0;
        rst_b = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        {reg_wr_en, reg_rd_en, io_update} = 3'h0;
        status_sources = '0;
        {eeprom_master_en, eeprom_scl_low, eeprom_sda_low} = 3'h0;
        ext_en = 7'h78;
        ext_val = 7'h38;
        cyc(2);
        rst_b = 1'b1;
        s_startup();
        s_status();
        s_control();
        test_done();
    end
endmodule

bind multifunction_pins multifunction_pins_properties #(.STRAP_CYCLES(STRAP_CYCLES)) u_multifunction_pins_properties (
    .core_clk, .rst_b, .eeprom_master_en, .eeprom_scl_low, .startup_done, .serial_is_i2c,
    .eeprom_autoload, .i2c_address, .multifunction_pin_in, .multifunction_pin_out,
    .multifunction_pin_oe, .multifunction_pin_weak);

// ==== src/mfpin_pkg.sv ====
// shared constants and types for the multifunction pin block
package mfpin_pkg;

    // sizes
    localparam int NUM_PINS  = 7;
    localparam int CODE_W    = 7;
    localparam int NUM_CODES = 128;
    localparam int REG_W     = 8;
    localparam int ADDR_W    = 16;
    localparam int RD_W      = 2;
    localparam int RD_VEC_W  = NUM_PINS * RD_W;

    // register offsets
    localparam logic [ADDR_W-1:0] RD_CODES_LOW_ADDR  = 16'h0100;
    localparam logic [ADDR_W-1:0] RD_CODES_HIGH_ADDR = 16'h0101;
    localparam logic [ADDR_W-1:0] FUNC_FIRST_ADDR    = 16'h0102;
    localparam logic [ADDR_W-1:0] FUNC_LAST_ADDR     = 16'h0108;
    localparam logic [ADDR_W-1:0] DRIVE_STRENGTH_ADDR = 16'h0109;
    localparam logic [ADDR_W-1:0] STARTUP_STATUS_ADDR = 16'h010A;

    // function register layout
    localparam int FUNC_DIR_BIT = 7;
    localparam logic [CODE_W-1:0] IGNORE_INPUT_FUNCTION = 7'h00;

    // receiver/driver field: bit 0 inverts, bit 1 selects the or-group / open drain
    localparam int RD_INVERT_BIT = 0;
    localparam int RD_OR_BIT     = 1;
    localparam logic [RD_W-1:0] RD_CMOS_HIGH  = 2'h0;
    localparam logic [RD_W-1:0] RD_CMOS_LOW   = 2'h1;
    localparam logic [RD_W-1:0] RD_PMOS_OPEN  = 2'h2;
    localparam logic [RD_W-1:0] RD_NMOS_OPEN  = 2'h3;

    // reset values
    localparam logic [REG_W-1:0]    FUNC_RESET  = 8'h00;
    localparam logic [RD_VEC_W-1:0] RD_RESET    = 14'h0000;
    localparam logic [NUM_PINS-1:0] DRIVE_RESET = 7'h00;

    // strap pins and eeprom master pins
    localparam int SCL_PIN          = 1;
    localparam int SDA_PIN          = 2;
    localparam int EEPROM_STRAP_PIN = 3;
    localparam int SERIAL_STRAP_PIN = 4;
    localparam int ADDR_LOW_PIN     = 5;
    localparam int ADDR_HIGH_PIN    = 6;
    localparam logic [CODE_W-1:0] I2C_ADDR_BASE = 7'h48;

    // startup status register bits
    localparam int ST_I2C_BIT    = 0;
    localparam int ST_EEPROM_BIT = 1;
    localparam int ST_RUN_BIT    = 2;
    localparam int ST_FREEZE_BIT = 3;

    // timing
    localparam int CLK_PERIOD_NS       = 20;
    localparam int STRAP_WINDOW_NS     = 1000;
    localparam int STRAP_WINDOW_CYCLES = (STRAP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {PH_STRAP, PH_RUN} phase_t;

endpackage

// ==== src/multifunction_pins.sv ====
// seven multifunction status/control pins with staged configuration and startup straps
`timescale 1ns/100ps
module multifunction_pins #(
    parameter int STRAP_CYCLES = mfpin_pkg::STRAP_WINDOW_CYCLES
) (
    // clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                rst_b,
    // register port
    input  wire logic [mfpin_pkg::ADDR_W-1:0]        reg_addr,
    input  wire logic                                reg_wr_en,
    input  wire logic [mfpin_pkg::REG_W-1:0]         reg_wdata,
    input  wire logic                                reg_rd_en,
    output logic      [mfpin_pkg::REG_W-1:0]         reg_rdata,
    // configuration update strobe
    input  wire logic                                io_update,
    // internal status sources and control destinations
    input  wire logic [mfpin_pkg::NUM_CODES-1:0]     status_sources,
    output logic      [mfpin_pkg::NUM_CODES-1:0]     control_dest,
    // eeprom loader acting as i2c master on pins 1 and 2
    input  wire logic                                eeprom_master_en,
    input  wire logic                                eeprom_scl_low,
    input  wire logic                                eeprom_sda_low,
    output logic                                     eeprom_sda_level,
    // startup configuration
    output logic                                     startup_done,
    output logic                                     serial_is_i2c,
    output logic                                     eeprom_autoload,
    output logic      [mfpin_pkg::CODE_W-1:0]        i2c_address,
    // multifunction_pin pads
    input  wire logic [mfpin_pkg::NUM_PINS-1:0]      multifunction_pin_in,
    output logic      [mfpin_pkg::NUM_PINS-1:0]      multifunction_pin_out,
    output logic      [mfpin_pkg::NUM_PINS-1:0]      multifunction_pin_oe,
    output logic      [mfpin_pkg::NUM_PINS-1:0]      multifunction_pin_weak
);

    localparam int NP     = mfpin_pkg::NUM_PINS;
    localparam int CNT_W  = $clog2(STRAP_CYCLES + 1);
    localparam int IDX_W  = $clog2(mfpin_pkg::NUM_PINS);

    // decodes the function register window; used by write and read paths
    function automatic logic func_hit(input logic [mfpin_pkg::ADDR_W-1:0] addr);
        func_hit = (addr >= mfpin_pkg::FUNC_FIRST_ADDR) && (addr <= mfpin_pkg::FUNC_LAST_ADDR);
    endfunction

    function automatic logic [IDX_W-1:0] func_pin(input logic [mfpin_pkg::ADDR_W-1:0] addr);
        logic [mfpin_pkg::ADDR_W-1:0] diff;
        diff     = addr - mfpin_pkg::FUNC_FIRST_ADDR;
        func_pin = diff[IDX_W-1:0];
    endfunction

    // synchronised pin levels
    logic [NP-1:0] pin_level;

    pin_input_sync #(
        .WIDTH     (NP)
    ) u_sync (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .pin_async (multifunction_pin_in),
        .pin_level (pin_level)
    );

    // startup phase
    mfpin_pkg::phase_t phase_ff;
    logic [CNT_W-1:0]  strap_cnt_ff;
    logic              strap_end;

    assign strap_end = (strap_cnt_ff == CNT_W'(STRAP_CYCLES - 1));

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            phase_ff     <= mfpin_pkg::PH_STRAP;
            strap_cnt_ff <= '0;
        end
        else
        begin
            case (phase_ff)
                mfpin_pkg::PH_STRAP:
                begin
                    strap_cnt_ff <= strap_cnt_ff + CNT_W'(1);
                    if (strap_end)
                        phase_ff <= mfpin_pkg::PH_RUN;
                end
                default:
                    strap_cnt_ff <= strap_cnt_ff;
            endcase
        end
    end

    // strap capture at the end of the window; later pin changes are ignored
    logic                             i2c_mode_ff;
    logic                             autoload_ff;
    logic [mfpin_pkg::CODE_W-1:0]     i2c_addr_ff;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            i2c_mode_ff <= 1'b0;
            autoload_ff <= 1'b0;
            i2c_addr_ff <= mfpin_pkg::I2C_ADDR_BASE;
        end
        else if (phase_ff == mfpin_pkg::PH_STRAP && strap_end)
        begin
            autoload_ff <= pin_level[mfpin_pkg::EEPROM_STRAP_PIN];
            i2c_mode_ff <= pin_level[mfpin_pkg::SERIAL_STRAP_PIN];
            i2c_addr_ff <= mfpin_pkg::I2C_ADDR_BASE
                         | {{(mfpin_pkg::CODE_W - 2){1'b0}},
                            pin_level[mfpin_pkg::ADDR_HIGH_PIN],
                            pin_level[mfpin_pkg::ADDR_LOW_PIN]};
        end
    end

    logic running;
    assign running = (phase_ff == mfpin_pkg::PH_RUN);

    // staged registers, written by software
    logic [mfpin_pkg::REG_W-1:0]    func_stage_ff [NP];
    logic [mfpin_pkg::RD_VEC_W-1:0] rd_stage_ff;
    logic [NP-1:0]                  drive_stage_ff;

    // active registers, loaded only by the update strobe
    logic [mfpin_pkg::REG_W-1:0]    func_act_ff [NP];
    logic [mfpin_pkg::RD_VEC_W-1:0] rd_act_ff;
    logic [NP-1:0]                  drive_act_ff;

    logic wr_func;
    logic [IDX_W-1:0] wr_pin;

    assign wr_func = reg_wr_en && func_hit(reg_addr);
    assign wr_pin  = func_pin(reg_addr);

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int p = 0; p < NP; p++)
                func_stage_ff[p] <= mfpin_pkg::FUNC_RESET;
        end
        else if (wr_func)
            func_stage_ff[wr_pin] <= reg_wdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rd_stage_ff    <= mfpin_pkg::RD_RESET;
            drive_stage_ff <= mfpin_pkg::DRIVE_RESET;
        end
        else if (reg_wr_en)
        begin
            if (reg_addr == mfpin_pkg::RD_CODES_LOW_ADDR)
                rd_stage_ff[mfpin_pkg::REG_W-1:0] <= reg_wdata;
            else if (reg_addr == mfpin_pkg::RD_CODES_HIGH_ADDR)
                rd_stage_ff[mfpin_pkg::RD_VEC_W-1:mfpin_pkg::REG_W] <=
                    reg_wdata[mfpin_pkg::RD_VEC_W-mfpin_pkg::REG_W-1:0];
            else if (reg_addr == mfpin_pkg::DRIVE_STRENGTH_ADDR)
                drive_stage_ff <= reg_wdata[NP-1:0];
        end
    end

    // staged copy moves over in one cycle so no pin sees a half-updated setup
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int p = 0; p < NP; p++)
                func_act_ff[p] <= mfpin_pkg::FUNC_RESET;
            rd_act_ff    <= mfpin_pkg::RD_RESET;
            drive_act_ff <= mfpin_pkg::DRIVE_RESET;
        end
        else if (io_update)
        begin
            for (int p = 0; p < NP; p++)
                func_act_ff[p] <= func_stage_ff[p];
            rd_act_ff    <= rd_stage_ff;
            drive_act_ff <= drive_stage_ff;
        end
    end

    // per-pin decode of the active configuration
    logic [NP-1:0]                 pin_is_out;
    logic [mfpin_pkg::CODE_W-1:0]  pin_code [NP];
    logic [mfpin_pkg::RD_W-1:0]    pin_rd   [NP];

    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            pin_is_out[p] = func_act_ff[p][mfpin_pkg::FUNC_DIR_BIT];
            pin_code[p]   = func_act_ff[p][mfpin_pkg::CODE_W-1:0];
            pin_rd[p]     = rd_act_ff[p*mfpin_pkg::RD_W +: mfpin_pkg::RD_W];
        end
    end

    // freeze of the control outputs; a function-register write to an input pin in the update cycle keeps it set
    logic freeze_ff;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            freeze_ff <= 1'b0;
        else if (wr_func && !pin_is_out[wr_pin])
            freeze_ff <= 1'b1;
        else if (io_update)
            freeze_ff <= 1'b0;
    end

    // control aggregation: or-group first, then and with the remaining terms
    logic [mfpin_pkg::NUM_CODES-1:0] nxt_control;

    always_comb
    begin
        logic has_any;
        logic has_or;
        logic or_res;
        logic and_res;
        logic term;
        has_any     = 1'b0;
        has_or      = 1'b0;
        or_res      = 1'b0;
        and_res     = 1'b1;
        term        = 1'b0;
        nxt_control = '0;
        for (int d = 1; d < mfpin_pkg::NUM_CODES; d++)
        begin
            has_any = 1'b0;
            has_or  = 1'b0;
            or_res  = 1'b0;
            and_res = 1'b1;
            for (int p = 0; p < NP; p++)
            begin
                if (!pin_is_out[p] && pin_code[p] == mfpin_pkg::CODE_W'(d))
                begin
                    term    = pin_level[p] ^ pin_rd[p][mfpin_pkg::RD_INVERT_BIT];
                    has_any = 1'b1;
                    if (pin_rd[p][mfpin_pkg::RD_OR_BIT])
                    begin
                        has_or = 1'b1;
                        or_res = or_res | term;
                    end
                    else
                        and_res = and_res & term;
                end
            end
            nxt_control[d] = has_any && and_res && (or_res || !has_or);
        end
    end

    // control outputs stay low through startup and hold while frozen
    logic [mfpin_pkg::NUM_CODES-1:0] control_ff;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            control_ff <= '0;
        else if (running && !freeze_ff)
            control_ff <= nxt_control;
    end

    // output stage; the eeprom master borrows pins 1 and 2 as open-drain i2c lines
    logic [NP-1:0]              drv_en;
    logic [NP-1:0]              drv_assert;
    logic [mfpin_pkg::RD_W-1:0] drv_style [NP];

    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            drv_en[p]     = running && pin_is_out[p];
            drv_assert[p] = status_sources[pin_code[p]];
            drv_style[p]  = pin_rd[p];
        end
        if (running && eeprom_master_en)
        begin
            drv_en[mfpin_pkg::SCL_PIN]     = 1'b1;
            drv_assert[mfpin_pkg::SCL_PIN] = eeprom_scl_low;
            drv_style[mfpin_pkg::SCL_PIN]  = mfpin_pkg::RD_NMOS_OPEN;
            drv_en[mfpin_pkg::SDA_PIN]     = 1'b1;
            drv_assert[mfpin_pkg::SDA_PIN] = eeprom_sda_low;
            drv_style[mfpin_pkg::SDA_PIN]  = mfpin_pkg::RD_NMOS_OPEN;
        end
    end

    for (genvar g = 0; g < NP; g++)
    begin : g_pin
        pin_driver u_drv (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .drive_en (drv_en[g]),
            .asserted (drv_assert[g]),
            .style    (drv_style[g]),
            .weak_sel (drive_act_ff[g]),
            .pin_out  (multifunction_pin_out[g]),
            .pin_oe   (multifunction_pin_oe[g]),
            .pin_weak (multifunction_pin_weak[g])
        );
    end

    // register read-back, one cycle after the read request
    logic [mfpin_pkg::REG_W-1:0] rdata_ff;
    logic [mfpin_pkg::REG_W-1:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = '0;
        if (reg_addr == mfpin_pkg::RD_CODES_LOW_ADDR)
            nxt_rdata = rd_stage_ff[mfpin_pkg::REG_W-1:0];
        else if (reg_addr == mfpin_pkg::RD_CODES_HIGH_ADDR)
            nxt_rdata = mfpin_pkg::REG_W'(rd_stage_ff[mfpin_pkg::RD_VEC_W-1:mfpin_pkg::REG_W]);
        else if (func_hit(reg_addr))
            nxt_rdata = func_stage_ff[func_pin(reg_addr)];
        else if (reg_addr == mfpin_pkg::DRIVE_STRENGTH_ADDR)
            nxt_rdata = mfpin_pkg::REG_W'(drive_stage_ff);
        else if (reg_addr == mfpin_pkg::STARTUP_STATUS_ADDR)
        begin
            nxt_rdata[mfpin_pkg::ST_I2C_BIT]    = i2c_mode_ff;
            nxt_rdata[mfpin_pkg::ST_EEPROM_BIT] = autoload_ff;
            nxt_rdata[mfpin_pkg::ST_RUN_BIT]    = running;
            nxt_rdata[mfpin_pkg::ST_FREEZE_BIT] = freeze_ff;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            rdata_ff <= '0;
        else if (reg_rd_en)
            rdata_ff <= nxt_rdata;
    end

    assign reg_rdata        = rdata_ff;
    assign control_dest     = control_ff;
    assign startup_done     = running;
    assign serial_is_i2c    = i2c_mode_ff;
    assign eeprom_autoload  = autoload_ff;
    assign i2c_address      = i2c_addr_ff;
    assign eeprom_sda_level = pin_level[mfpin_pkg::SDA_PIN];

endmodule

// ==== src/pin_driver.sv ====
// output stage of one multifunction pin: style, enable and strength
`timescale 1ns/100ps
module pin_driver (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    // configuration and source
    input  wire logic                        drive_en,
    input  wire logic                        asserted,
    input  wire logic [mfpin_pkg::RD_W-1:0]  style,
    input  wire logic                        weak_sel,
    // pin side
    output logic                             pin_out,
    output logic                             pin_oe,
    output logic                             pin_weak
);

    logic out_ff;
    logic oe_ff;
    logic weak_ff;

    // released until enabled; open-drain styles float when their level is not driven
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            out_ff  <= 1'b0;
            oe_ff   <= 1'b0;
            weak_ff <= 1'b0;
        end
        else if (!drive_en)
        begin
            out_ff  <= 1'b0;
            oe_ff   <= 1'b0;
            weak_ff <= 1'b0;
        end
        else
        begin
            // open-drain styles only drive while asserted, so weak follows the real drive
            weak_ff <= weak_sel && (!style[mfpin_pkg::RD_OR_BIT] || asserted);
            case (style)
                mfpin_pkg::RD_CMOS_HIGH:
                begin
                    out_ff <= asserted;
                    oe_ff  <= 1'b1;
                end
                mfpin_pkg::RD_CMOS_LOW:
                begin
                    out_ff <= !asserted;
                    oe_ff  <= 1'b1;
                end
                mfpin_pkg::RD_PMOS_OPEN:
                begin
                    out_ff <= 1'b1;
                    oe_ff  <= asserted;
                end
                default:
                begin
                    out_ff <= 1'b0;
                    oe_ff  <= asserted;
                end
            endcase
        end
    end

    assign pin_out  = out_ff;
    assign pin_oe   = oe_ff;
    assign pin_weak = weak_ff;

endmodule

// ==== src/pin_input_sync.sv ====
// three-stage synchroniser with agreement filter for the pin levels
`timescale 1ns/100ps
module pin_input_sync #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // asynchronous pin levels in, filtered levels out
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_level
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] late_ff;
    logic [WIDTH-1:0] level_ff;

    always_ff @(posedge core_clk)
    begin
        meta_ff <= pin_async;
        sync_ff <= meta_ff;
        late_ff <= sync_ff;
    end

    // a bit changes only once the second and third stages agree
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            level_ff <= '0;
        else
            level_ff <= (sync_ff & late_ff) | (level_ff & (sync_ff | late_ff));
    end

    assign pin_level = level_ff;

endmodule
